// *** irq_defines.vh ***
// register map, field positions and reset values of the tag interrupt block
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH

`define ADDR_IRQ_MASK_LOW    8'h08
`define ADDR_IRQ_MASK_HIGH   8'h09
`define ADDR_IRQ_FLAGS_LOW   8'h0A
`define ADDR_IRQ_FLAGS_HIGH  8'h0B

`define FLAGS_RESET          8'h00
`define MASK_RESET           8'hFF
`define READ_UNMAPPED        8'h00

// bit positions in the low flag and mask registers
`define BIT_INIT             7
`define BIT_WAKE_SELECTED    6
`define BIT_SLEEP_REQ        5
`define BIT_READER_WROTE     4
`define BIT_READER_READ      3
`define BIT_RX_END           2
`define BIT_TX_END           1
`define BIT_FIELD_EXIT       0

// bit positions in the high flag and mask registers
`define BIT_RX_START         7
`define BIT_FRAMING_ERR      6
`define BIT_PARITY_ERR       5
`define BIT_CRC_ERR          4
`define BIT_BUFFER_FAULT     3
`define BIT_PROG_DONE        2
`define BIT_MEM_ACCESS_ERR   1
`define BIT_HOST_ACCESS_ERR  0

// protocol state code of the selected state
`define STATE_SELECTED       4'h6

`endif

// *** flag_bank.v ***
// one 8-bit sticky flag register with clear-all and set-wins priority
`default_nettype none

module flag_bank #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] set_i,
  input  wire             clear_i,
  output reg  [WIDTH-1:0] flags_o
);

  wire [WIDTH-1:0] next_flags;

  // an event in the clearing cycle survives the clear
  assign next_flags = (flags_o & {WIDTH{~clear_i}}) | set_i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= {WIDTH{1'b0}};
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule

`default_nettype wire

// *** edge_detect.v ***
// rising and falling edge pulses for a group of same-clock level signals
`default_nettype none

module edge_detect #(
  parameter WIDTH = 2
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);

  reg [WIDTH-1:0] prev;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= {WIDTH{1'b0}};
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
  assign fall_o = ~level_i & prev;

endmodule

`default_nettype wire

// *** tag_irq_ctrl.v ***
// interrupt flag and mask registers of the tag with the host-facing interrupt line
`include "irq_defines.vh"
`default_nettype none

// Functional notes
// - masks gate only the line, flags always latch
// - masks load defaults from nonvolatile configuration words
// - reading a flag register clears it
// - power-up and restore-defaults clear both flag registers
// - init flag on power-up, field, listed commands
// - wake flag on entry to selected state
// - sleep flag on sleep request command
// - flag when reader updated the data area
// - flag when reader read the data area
// - receive-end flag in buffered receive modes
// - transmit-end and field-exit flags
// - receive-start flag in buffered receive modes
// - framing error flag, data still buffered
// - parity error flag, data still buffered
// - crc error flag, data still buffered
// - buffer fault flag on overflow or underflow
// - programming-done flag for host-issued writes
// - memory access error on protected or missing address
// - host access error on access control interruption
module tag_irq_ctrl (
  input  wire       SYS_CLK_I,
  input  wire       RESET_I,
  input  wire [7:0] REG_ADDR_I,
  input  wire [7:0] REG_WDATA_I,
  input  wire       REG_WR_I,
  input  wire       REG_RD_I,
  output reg  [7:0] REG_RDATA_O,
  output reg        REG_RVALID_O,
  input  wire       CFG_LOAD_I,
  input  wire [7:0] MASK_DEFAULT_WORD_LOW_I,
  input  wire [7:0] MASK_DEFAULT_WORD_HIGH_I,
  input  wire       FIELD_PRESENT_I,
  input  wire       CMD_GO_SLEEP_I,
  input  wire       CMD_GO_SENSE_I,
  input  wire       CMD_GO_SENSE_SLEEP_I,
  input  wire       CMD_RESTORE_DEFAULTS_I,
  input  wire [3:0] PROTO_STATE_I,
  input  wire       SLEEP_REQ_I,
  input  wire       READER_WROTE_AREA_I,
  input  wire       READER_READ_AREA_I,
  input  wire       BUFFER_MODE_I,
  input  wire       RX_FRAME_START_I,
  input  wire       RX_FRAME_END_I,
  input  wire       TX_BUFFER_DONE_I,
  input  wire       FRAMING_ERROR_I,
  input  wire       PARITY_ERROR_I,
  input  wire       CRC_ERROR_I,
  input  wire       BUFFER_OVERFLOW_I,
  input  wire       BUFFER_UNDERFLOW_I,
  input  wire       NVM_WRITE_DONE_I,
  input  wire       NVM_WRITE_BY_HOST_I,
  input  wire       NVM_WRITE_PROTECTED_I,
  input  wire       NVM_WRITE_NO_ADDR_I,
  input  wire       HOST_ACCESS_DENIED_I,
  output reg        IRQ_O
);

  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  function any_pending;
    input [7:0] flags;
    input [7:0] mask;
    begin
      any_pending = |(flags & ~mask);
    end
  endfunction

  reg  [7:0] irq_mask_low;
  reg  [7:0] irq_mask_high;
  reg        powered_up;
  reg  [7:0] next_rdata;

  wire [7:0] irq_flags_low;
  wire [7:0] irq_flags_high;
  reg  [7:0] set_low;
  reg  [7:0] set_high;

  wire       rd_flags_low;
  wire       rd_flags_high;
  wire       wr_mask_low;
  wire       wr_mask_high;
  wire       clear_low;
  wire       clear_high;
  wire       power_up_event;
  wire       in_selected;
  wire [1:0] lvl_rise;
  wire [1:0] lvl_fall;
  wire       field_appear;
  wire       field_exit;
  wire       selected_entry;
  wire       init_event;
  wire       wake_selected_flag;
  wire       reader_wrote_area_flag;
  wire       reader_read_area_flag;
  wire       buffer_fault_flag;
  wire       wake_selected_mask;
  wire       next_irq;

  assign rd_flags_low  = REG_RD_I & addr_is(REG_ADDR_I, `ADDR_IRQ_FLAGS_LOW);
  assign rd_flags_high = REG_RD_I & addr_is(REG_ADDR_I, `ADDR_IRQ_FLAGS_HIGH);
  assign wr_mask_low   = REG_WR_I & addr_is(REG_ADDR_I, `ADDR_IRQ_MASK_LOW);
  assign wr_mask_high  = REG_WR_I & addr_is(REG_ADDR_I, `ADDR_IRQ_MASK_HIGH);

  // power-up one-shot: first clock after reset release, not a reset value
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      powered_up <= 1'b0;
    end else begin
      powered_up <= 1'b1;
    end
  end

  assign power_up_event = ~powered_up;

  assign in_selected = (PROTO_STATE_I == `STATE_SELECTED);

  edge_detect #(
    .WIDTH (2)
  ) u_edges (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .level_i ({in_selected, FIELD_PRESENT_I}),
    .rise_o  (lvl_rise),
    .fall_o  (lvl_fall)
  );

  // a field rise is ignored in the power-up cycle, which sets init anyway; a field fall is not
  assign field_appear   = lvl_rise[0] & powered_up;
  assign field_exit     = lvl_fall[0];
  assign selected_entry = lvl_rise[1];

  assign init_event = power_up_event | field_appear | CMD_GO_SLEEP_I | CMD_GO_SENSE_I
                    | CMD_GO_SENSE_SLEEP_I | CMD_RESTORE_DEFAULTS_I;

  // event vector of the low flag register
  always @* begin
    set_low = 8'h00;
    set_low[`BIT_INIT]          = init_event;
    set_low[`BIT_WAKE_SELECTED] = selected_entry;
    set_low[`BIT_SLEEP_REQ]     = SLEEP_REQ_I;
    set_low[`BIT_READER_WROTE]  = READER_WROTE_AREA_I;
    set_low[`BIT_READER_READ]   = READER_READ_AREA_I;
    set_low[`BIT_RX_END]        = RX_FRAME_END_I & BUFFER_MODE_I;
    set_low[`BIT_TX_END]        = TX_BUFFER_DONE_I;
    set_low[`BIT_FIELD_EXIT]    = field_exit;
  end

  // event vector of the high flag register; errors never hold back the
  // buffer write path, so received bytes are stored whatever is flagged
  always @* begin
    set_high = 8'h00;
    set_high[`BIT_RX_START]        = RX_FRAME_START_I & BUFFER_MODE_I;
    set_high[`BIT_FRAMING_ERR]     = FRAMING_ERROR_I;
    set_high[`BIT_PARITY_ERR]      = PARITY_ERROR_I;
    set_high[`BIT_CRC_ERR]         = CRC_ERROR_I;
    set_high[`BIT_BUFFER_FAULT]    = BUFFER_OVERFLOW_I | BUFFER_UNDERFLOW_I;
    set_high[`BIT_PROG_DONE]       = NVM_WRITE_DONE_I & NVM_WRITE_BY_HOST_I;
    set_high[`BIT_MEM_ACCESS_ERR]  = NVM_WRITE_PROTECTED_I | NVM_WRITE_NO_ADDR_I;
    set_high[`BIT_HOST_ACCESS_ERR] = HOST_ACCESS_DENIED_I;
  end

  // clear after the read; reset covers power-up clearing
  assign clear_low  = rd_flags_low | CMD_RESTORE_DEFAULTS_I;
  assign clear_high = rd_flags_high | CMD_RESTORE_DEFAULTS_I;

  // flags latch regardless of the mask bits
  flag_bank #(
    .WIDTH (8)
  ) u_flags_low (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .set_i   (set_low),
    .clear_i (clear_low),
    .flags_o (irq_flags_low)
  );

  flag_bank #(
    .WIDTH (8)
  ) u_flags_high (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .set_i   (set_high),
    .clear_i (clear_high),
    .flags_o (irq_flags_high)
  );

  assign wake_selected_flag     = irq_flags_low[`BIT_WAKE_SELECTED];
  assign reader_wrote_area_flag = irq_flags_low[`BIT_READER_WROTE];
  assign reader_read_area_flag  = irq_flags_low[`BIT_READER_READ];
  assign buffer_fault_flag      = irq_flags_high[`BIT_BUFFER_FAULT];
  assign wake_selected_mask     = irq_mask_low[`BIT_WAKE_SELECTED];

  // masks come up fully masked until the configuration words arrive;
  // a host write in the same cycle as the load is overridden by the load
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_mask_low  <= `MASK_RESET;
      irq_mask_high <= `MASK_RESET;
    end else if (CFG_LOAD_I) begin
      irq_mask_low  <= MASK_DEFAULT_WORD_LOW_I;
      irq_mask_high <= MASK_DEFAULT_WORD_HIGH_I;
    end else begin
      if (wr_mask_low) begin
        irq_mask_low <= REG_WDATA_I;
      end
      if (wr_mask_high) begin
        irq_mask_high <= REG_WDATA_I;
      end
    end
  end

  // read data are the values before the clear takes effect
  always @* begin
    next_rdata = `READ_UNMAPPED;
    case (REG_ADDR_I)
      `ADDR_IRQ_MASK_LOW: begin
        next_rdata = irq_mask_low;
      end
      `ADDR_IRQ_MASK_HIGH: begin
        next_rdata = irq_mask_high;
      end
      `ADDR_IRQ_FLAGS_LOW: begin
        next_rdata = irq_flags_low;
      end
      `ADDR_IRQ_FLAGS_HIGH: begin
        next_rdata = irq_flags_high;
      end
      default: begin
        next_rdata = `READ_UNMAPPED;
      end
    endcase
  end

  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O  <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  // mask bit of one suppresses its source on the line only
  assign next_irq = any_pending(irq_flags_low, irq_mask_low)
                  | any_pending(irq_flags_high, irq_mask_high);

  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= next_irq;
    end
  end

endmodule

`default_nettype wire

// *** host_port.sv ***
// host-side model of the byte register port
`default_nettype none
module host_port (
  input  wire logic       clk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // entered and left just after a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // released lines never keep a stale value
    addr_o = ~a;
    wdata_o = ~d;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    d = rdata_i;
    v = rvalid_i;
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tag_irq_props.sv ***
// port-level assertions for the tag interrupt block
`default_nettype none
module tag_irq_props (
  input wire logic       SYS_CLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       REG_RVALID_O,
  input wire logic       CFG_LOAD_I,
  input wire logic [7:0] MASK_DEFAULT_WORD_LOW_I,
  input wire logic [7:0] MASK_DEFAULT_WORD_HIGH_I,
  input wire logic       FIELD_PRESENT_I,
  input wire logic [3:0] PROTO_STATE_I,
  input wire logic       SLEEP_REQ_I,
  input wire logic       CMD_RESTORE_DEFAULTS_I,
  input wire logic       HOST_ACCESS_DENIED_I,
  input wire logic       IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mlo;
  logic [7:0] mhi;
  // mask shadow; a load beats a write in the same cycle
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mlo <= 8'hFF;
      mhi <= 8'hFF;
    end else if (CFG_LOAD_I) begin
      mlo <= MASK_DEFAULT_WORD_LOW_I;
      mhi <= MASK_DEFAULT_WORD_HIGH_I;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == 8'h08) mlo <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h09) mhi <= REG_WDATA_I;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_rd_lo;
    REG_RD_I && REG_ADDR_I == 8'h0A;
  endsequence
  sequence s_rd_hi;
    REG_RD_I && REG_ADDR_I == 8'h0B;
  endsequence
  property p_rvalid;
    REG_RVALID_O == $past(REG_RD_I);
  endproperty
  property p_masked;
    (mlo == 8'hFF && mhi == 8'hFF) |=> !IRQ_O;
  endproperty
  property p_unmasked;
    (SLEEP_REQ_I && !mlo[5]) ##1 !mlo[5] |=> IRQ_O;
  endproperty
  property p_host_err;
    HOST_ACCESS_DENIED_I ##1 s_rd_hi |=> REG_RDATA_O[0];
  endproperty
  property p_restore;
    CMD_RESTORE_DEFAULTS_I ##1 s_rd_lo |=> REG_RDATA_O[7];
  endproperty
  property p_field_exit;
    $fell(FIELD_PRESENT_I) ##1 s_rd_lo |=> REG_RDATA_O[0];
  endproperty
  property p_wake;
    $rose(PROTO_STATE_I == 4'h6) ##1 s_rd_lo |=> REG_RDATA_O[6];
  endproperty
  property p_mask_rd;
    (REG_RD_I && REG_ADDR_I == 8'h08) |=> REG_RDATA_O == $past(mlo);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid off");
  a_masked: assert property (p_masked) else $error("masked line rose");
  a_unmasked: assert property (p_unmasked) else $error("line missing");
  a_host_err: assert property (p_host_err) else $error("host err lost");
  a_restore: assert property (p_restore) else $error("init lost");
  a_field_exit: assert property (p_field_exit) else $error("exit lost");
  a_wake: assert property (p_wake) else $error("wake lost");
  a_mask_rd: assert property (p_mask_rd) else $error("mask read off");
endmodule
bind tag_irq_ctrl tag_irq_props u_props (.*);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the tag interrupt block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cfg, field, bmode, byhost, wr, rd, rvalid, irq;
  logic [3:0]  state;
  logic [18:0] ev;
  logic [7:0]  addr, wdata, rdata, m;
  int          num_errors, total_checks;
  // bit of each event, bit 4 set means the upper flag register
  localparam logic [7:0] MAP [18] = '{8'h07, 8'h07, 8'h07, 8'h05, 8'h04, 8'h03,
    8'h17, 8'h02, 8'h01, 8'h16, 8'h15, 8'h14, 8'h13, 8'h13, 8'h12, 8'h11, 8'h11, 8'h10};
  tag_irq_ctrl u_dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .CFG_LOAD_I(cfg), .MASK_DEFAULT_WORD_LOW_I(8'hA5), .MASK_DEFAULT_WORD_HIGH_I(8'h00),
    .FIELD_PRESENT_I(field), .CMD_GO_SLEEP_I(ev[0]), .CMD_GO_SENSE_I(ev[1]),
    .CMD_GO_SENSE_SLEEP_I(ev[2]), .CMD_RESTORE_DEFAULTS_I(ev[18]), .PROTO_STATE_I(state),
    .SLEEP_REQ_I(ev[3]), .READER_WROTE_AREA_I(ev[4]), .READER_READ_AREA_I(ev[5]),
    .BUFFER_MODE_I(bmode), .RX_FRAME_START_I(ev[6]), .RX_FRAME_END_I(ev[7]),
    .TX_BUFFER_DONE_I(ev[8]), .FRAMING_ERROR_I(ev[9]), .PARITY_ERROR_I(ev[10]),
    .CRC_ERROR_I(ev[11]), .BUFFER_OVERFLOW_I(ev[12]), .BUFFER_UNDERFLOW_I(ev[13]),
    .NVM_WRITE_DONE_I(ev[14]), .NVM_WRITE_BY_HOST_I(byhost),
    .NVM_WRITE_PROTECTED_I(ev[15]), .NVM_WRITE_NO_ADDR_I(ev[16]),
    .HOST_ACCESS_DENIED_I(ev[17]), .IRQ_O(irq));
  host_port u_host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk(d, e);
    chk({7'h00, v}, 8'h01);
  endtask
  task automatic fire(input int i);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    {cfg, field, bmode, byhost, state, ev} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rdc(8'h08, 8'hFF);
    rdc(8'h0A, 8'h80);
    rdc(8'h0B, 8'h00);
    rdc(8'h0A, 8'h00);
    u_host.wr(8'h0A, 8'hFF);
    rdc(8'h0A, 8'h00);
    rdc(8'h0C, 8'h00);
    cfg = 1'b1;
    @(negedge clk);
    cfg = 1'b0;
    rdc(8'h08, 8'hA5);
    u_host.wr(8'h08, 8'h00);
    rdc(8'h08, 8'h00);
    bmode = 1'b1;
    byhost = 1'b1;
    // every event source but restore-defaults, field and state, each alone, with all masks open
    for (int i = 0; i < 18; i++) begin
      m = MAP[i];
      fire(i);
      @(negedge clk);
      chk({7'h00, irq}, 8'h01);
      rdc(8'h0B, m[4] ? 8'h01 << m[2:0] : 8'h00);
      rdc(8'h0A, m[4] ? 8'h00 : 8'h01 << m[2:0]);
      chk({7'h00, irq}, 8'h00);
    end
    field = 1'b1;
    @(negedge clk);
    rdc(8'h0A, 8'h80);
    field = 1'b0;
    @(negedge clk);
    rdc(8'h0A, 8'h01);
    state = 4'h6;
    @(negedge clk);
    rdc(8'h0A, 8'h40);
    state = 4'h1;
    bmode = 1'b0;
    byhost = 1'b0;
    fire(6);
    fire(7);
    fire(14);
    rdc(8'h0B, 8'h00);
    rdc(8'h0A, 8'h00);
    fire(17);
    rdc(8'h0B, 8'h01);
    u_host.wr(8'h08, 8'hFF);
    u_host.wr(8'h09, 8'hFF);
    fire(3);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rdc(8'h0A, 8'h20);
    fire(9);
    fire(3);
    fire(18);
    rdc(8'h0A, 8'h80);
    rdc(8'h0B, 8'h00);
    // second power-up with a flag pending: flags clear, init comes back
    fire(9);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rdc(8'h0B, 8'h00);
    rdc(8'h0A, 8'h80);
    rdc(8'h08, 8'hFF);
    close_out();
  end
endmodule
`default_nettype wire
